// ### src/pbcaf_pkg.sv
// pbcaf_pkg: constants, modes and the state record of the port b/c
// alternate-function override block.
// assumes: one 50 MHz system clock, synchronous active-low reset.
package pbcaf_pkg;

    // =========================================================
    // pin counts and indices (pb0..pb3 then pc0..pc4)
    localparam int PBCAF_PB_PINS = 4;
    localparam int PBCAF_PC_PINS = 5;
    localparam int PBCAF_ALL_PINS = 9;
    localparam int PBCAF_PC_IN_PINS = 6;
    localparam int PBCAF_PB0 = 0;
    localparam int PBCAF_PB1 = 1;
    localparam int PBCAF_PB2 = 2;
    localparam int PBCAF_PB3 = 3;
    localparam int PBCAF_PC0 = 4;
    localparam int PBCAF_PC1 = 5;
    localparam int PBCAF_PC2 = 6;
    localparam int PBCAF_PC3 = 7;
    localparam int PBCAF_PC4 = 8;

    // =========================================================
    // pin change sources 8..17, converter channels 5..11
    localparam int PBCAF_PCINT_LSB = 8;
    localparam int PBCAF_PCINT_W = 10;
    localparam int PBCAF_PB_PCINT_BASE = 8;
    localparam int PBCAF_PC_PCINT_BASE = 12;
    localparam int PBCAF_PC5_PCINT = 17;
    localparam int PBCAF_ADC_LSB = 5;
    localparam int PBCAF_ADC_W = 7;
    localparam int PBCAF_PB0_ADC = 5;
    localparam int PBCAF_PC0_ADC = 9;

    // =========================================================
    // fuse levels: programmed reads as zero
    localparam logic PBCAF_FUSE_PROGRAMMED = 1'h0;

    // =========================================================
    // values after reset
    localparam logic [8:0] PBCAF_RST_PINS = 9'h000;
    localparam logic [9:0] PBCAF_RST_PCINT = 10'h000;
    localparam logic PBCAF_RST_LOW = 1'h0;
    localparam logic PBCAF_RST_HIGH = 1'h1;

    typedef enum logic [1:0] {
        PBCAF_CLK_INT_CAL = 2'h0,
        PBCAF_CLK_EXT_CLOCK = 2'h1,
        PBCAF_CLK_CRYSTAL = 2'h2,
        PBCAF_CLK_LF_CRYSTAL = 2'h3
    } pbcaf_clk_src_t;

    typedef struct packed {
        logic [8:0] pull_up;
        logic [8:0] drive_en;
        logic [8:0] out_value;
        logic [8:0] input_en;
        logic [9:0] pin_change_src;
        logic clk_image;
        logic ext_reset_n;
        logic debug_in;
        logic serial1_rx;
        logic serial0_rx_unused;
        logic iface_data_in;
        logic iface_clock_in;
        logic capture_in;
        logic irq_zero_in;
        logic serial0_clk_in;
        logic serial1_clk_in;
    } pbcaf_state_t;

endpackage

// ### src/pbcaf_pin_cell.sv
// pbcaf_pin_cell: override multiplexer for one port pin.
// assumes: purely combinational, the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
module pbcaf_pin_cell (
    input wire logic i_latch,
    input wire logic i_dir,
    input wire logic i_pin,
    input wire logic i_pull_ovr_en,
    input wire logic i_pull_ovr_val,
    input wire logic i_dir_ovr_en,
    input wire logic i_dir_ovr_val,
    input wire logic i_port_value_override_enable,
    input wire logic i_value_ovr_val,
    input wire logic i_input_enable_override_enable,
    input wire logic i_input_ovr_val,
    output logic o_pull_up,
    output logic o_drive_en,
    output logic o_out_value,
    output logic o_input_en,
    output logic o_data_in
);
    // =========================================================
    // select override or ordinary port value
    always_comb begin
        o_pull_up = i_pull_ovr_en ? i_pull_ovr_val : (i_latch & ~i_dir);
        o_drive_en = i_dir_ovr_en ? i_dir_ovr_val : i_dir;
        o_out_value = i_port_value_override_enable ? i_value_ovr_val : i_latch;
        o_input_en = i_input_enable_override_enable ? i_input_ovr_val : 1'h1;
        o_data_in = i_pin & o_input_en;
    end
endmodule
`default_nettype wire

// ### src/pbcaf_override.sv
// pbcaf_override: alternate-function override for pins pb0..pb3 and pc0..pc4.
// assumes: pins, peripherals and fuses are synchronous to i_clk; pad logic
// resolves drive enable, output value and pull-up into the wire level.
`timescale 1ns/10ps
`default_nettype none
module pbcaf_override (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [pbcaf_pkg::PBCAF_PB_PINS-1:0] i_pb_latch,
    input wire logic [pbcaf_pkg::PBCAF_PB_PINS-1:0] i_pb_dir,
    input wire logic [pbcaf_pkg::PBCAF_PB_PINS-1:0] i_pin_pb,
    input wire logic [pbcaf_pkg::PBCAF_PC_PINS-1:0] i_pc_latch,
    input wire logic [pbcaf_pkg::PBCAF_PC_PINS-1:0] i_pc_dir,
    input wire logic [pbcaf_pkg::PBCAF_PC_IN_PINS-1:0] i_pin_pc,
    input wire logic [pbcaf_pkg::PBCAF_PCINT_W-1:0] i_pin_change_mask,
    input wire logic i_pin_change_group1_enable,
    input wire logic i_pin_change_group2_enable,
    input wire logic [pbcaf_pkg::PBCAF_ADC_W-1:0] i_conv_dig_input_disable,
    input wire logic i_serial0_tx_enable,
    input wire logic i_serial0_transmit,
    input wire logic i_serial1_tx_enable,
    input wire logic i_serial1_transmit,
    input wire logic i_serial1_rx_enable,
    input wire logic i_serial_iface_three_wire_mode,
    input wire logic i_serial_iface_two_wire_mode,
    input wire logic i_serial_iface_data_out,
    input wire logic i_serial_iface_sda_hold,
    input wire logic i_serial_iface_scl_hold,
    input wire logic i_serial_start_detect_enable,
    input wire logic i_timer1_match_a_enable,
    input wire logic i_timer1_match_a_wave,
    input wire logic i_timer0_match_a_enable,
    input wire logic i_timer0_match_a_wave,
    input wire logic i_serial0_sync_mode,
    input wire logic i_serial0_clock_out_enable,
    input wire logic i_serial0_sync_clock,
    input wire logic i_serial1_sync_mode,
    input wire logic i_serial1_clock_out_enable,
    input wire logic i_serial1_sync_clock,
    input wire logic i_external_irq_zero_enable,
    input wire logic i_clock_output_fuse,
    input wire logic i_reset_pin_disable_fuse,
    input wire logic i_debug_link_enable_fuse,
    input wire logic i_lock_bits_unprogrammed,
    input wire logic i_debug_pull_low,
    input wire pbcaf_pkg::pbcaf_clk_src_t i_clock_source,
    output logic [pbcaf_pkg::PBCAF_ALL_PINS-1:0] o_pull_up,
    output logic [pbcaf_pkg::PBCAF_ALL_PINS-1:0] o_drive_en,
    output logic [pbcaf_pkg::PBCAF_ALL_PINS-1:0] o_out_value,
    output logic [pbcaf_pkg::PBCAF_ALL_PINS-1:0] o_input_en,
    output logic [pbcaf_pkg::PBCAF_PCINT_W-1:0] o_pin_change_src,
    output logic o_external_reset_n,
    output logic o_debug_link_in,
    output logic o_serial1_receive,
    output logic o_serial_iface_data_in,
    output logic o_serial_iface_clock_in,
    output logic o_timer1_capture_input,
    output logic o_external_irq_zero,
    output logic o_serial0_sync_clock_in,
    output logic o_serial1_sync_clock_in
);
    import pbcaf_pkg::*;

    // =========================================================
    // override terms, one bit per pin
    logic [PBCAF_ALL_PINS-1:0] pin_latch;
    logic [PBCAF_ALL_PINS-1:0] pin_dir;
    logic [PBCAF_ALL_PINS-1:0] pin_level;
    logic [PBCAF_ALL_PINS-1:0] pull_ovr_en;
    logic [PBCAF_ALL_PINS-1:0] pull_ovr_val;
    logic [PBCAF_ALL_PINS-1:0] dir_ovr_en;
    logic [PBCAF_ALL_PINS-1:0] dir_ovr_val;
    logic [PBCAF_ALL_PINS-1:0] port_value_override_enable;
    logic [PBCAF_ALL_PINS-1:0] value_ovr_val;
    logic [PBCAF_ALL_PINS-1:0] input_enable_override_enable;
    logic [PBCAF_ALL_PINS-1:0] input_ovr_val;
    logic [PBCAF_ALL_PINS-1:0] cell_pull;
    logic [PBCAF_ALL_PINS-1:0] cell_drive;
    logic [PBCAF_ALL_PINS-1:0] cell_out;
    logic [PBCAF_ALL_PINS-1:0] cell_in_en;
    logic [PBCAF_ALL_PINS-1:0] cell_di;
    logic [PBCAF_ALL_PINS-1:0] pc_term;
    logic [PBCAF_ADC_W-1:0] adc_off;
    logic reset_role;
    logic debug_role;
    logic clock_out_on;
    logic xtal_role;
    pbcaf_state_t state;
    pbcaf_state_t next_state;

    assign pin_latch = {i_pc_latch, i_pb_latch};
    assign pin_dir = {i_pc_dir, i_pb_dir};
    assign pin_level = {i_pin_pc[PBCAF_PC_PINS-1:0], i_pin_pb};
    assign adc_off = i_conv_dig_input_disable;

    // =========================================================
    // pin change qualifiers
    always_comb begin
        for (int k = 0; k < PBCAF_PB_PINS; k++) begin
            pc_term[k] = i_pin_change_mask[PBCAF_PB_PCINT_BASE - PBCAF_PCINT_LSB + k]
                & i_pin_change_group1_enable;
        end
        for (int k = 0; k < PBCAF_PC_PINS; k++) begin
            pc_term[PBCAF_PC0 + k] = i_pin_change_mask[PBCAF_PC_PCINT_BASE - PBCAF_PCINT_LSB + k]
                & i_pin_change_group2_enable;
        end
    end

    // =========================================================
    // fuse and clock-source roles
    // clock fuse decode
    assign clock_out_on = (i_clock_output_fuse == PBCAF_FUSE_PROGRAMMED);
    assign reset_role = (i_reset_pin_disable_fuse != PBCAF_FUSE_PROGRAMMED) & ~debug_role;
    assign debug_role = (i_debug_link_enable_fuse == PBCAF_FUSE_PROGRAMMED) & i_lock_bits_unprogrammed;
    assign xtal_role = (i_clock_source != PBCAF_CLK_INT_CAL) & (i_clock_source != PBCAF_CLK_EXT_CLOCK);

    // =========================================================
    // per-pin override terms
    always_comb begin
        pull_ovr_en = PBCAF_RST_PINS;
        pull_ovr_val = PBCAF_RST_PINS;
        dir_ovr_en = PBCAF_RST_PINS;
        dir_ovr_val = PBCAF_RST_PINS;
        port_value_override_enable = PBCAF_RST_PINS;
        value_ovr_val = PBCAF_RST_PINS;
        input_enable_override_enable = PBCAF_RST_PINS;
        input_ovr_val = PBCAF_RST_PINS;

        // pb0: transmitter 0 owns the pin while enabled
        pull_ovr_en[PBCAF_PB0] = i_serial0_tx_enable;
        dir_ovr_en[PBCAF_PB0] = i_serial0_tx_enable;
        dir_ovr_val[PBCAF_PB0] = 1'h1;
        port_value_override_enable[PBCAF_PB0] = i_serial0_tx_enable;
        value_ovr_val[PBCAF_PB0] = i_serial0_transmit;
        input_enable_override_enable[PBCAF_PB0] = pc_term[PBCAF_PB0] | adc_off[PBCAF_PB0_ADC - PBCAF_ADC_LSB];
        input_ovr_val[PBCAF_PB0] = pc_term[PBCAF_PB0];

        dir_ovr_en[PBCAF_PB1] = i_serial1_rx_enable | i_serial_iface_two_wire_mode;
        dir_ovr_val[PBCAF_PB1] = ~i_serial1_rx_enable & i_serial_iface_two_wire_mode
            & (i_serial_iface_sda_hold | pin_latch[PBCAF_PB1]) & pin_dir[PBCAF_PB1];
        // open-drain: value forced low, only the direction moves
        port_value_override_enable[PBCAF_PB1] = ~i_serial1_rx_enable & i_serial_iface_two_wire_mode
            & pin_dir[PBCAF_PB1];
        value_ovr_val[PBCAF_PB1] = 1'h0;
        input_enable_override_enable[PBCAF_PB1] = i_serial_start_detect_enable | pc_term[PBCAF_PB1]
            | adc_off[PBCAF_PB0_ADC - PBCAF_ADC_LSB + 1];
        input_ovr_val[PBCAF_PB1] = i_serial_start_detect_enable | pc_term[PBCAF_PB1];

        // pull-up only taken by transmitter 1
        pull_ovr_en[PBCAF_PB2] = i_serial1_tx_enable;
        dir_ovr_en[PBCAF_PB2] = i_serial1_tx_enable;
        dir_ovr_val[PBCAF_PB2] = 1'h1;
        port_value_override_enable[PBCAF_PB2] = i_serial1_tx_enable | i_serial_iface_three_wire_mode;
        value_ovr_val[PBCAF_PB2] = i_serial1_tx_enable ? i_serial1_transmit : i_serial_iface_data_out;
        input_enable_override_enable[PBCAF_PB2] = pc_term[PBCAF_PB2] | adc_off[PBCAF_PB0_ADC - PBCAF_ADC_LSB + 2];
        input_ovr_val[PBCAF_PB2] = pc_term[PBCAF_PB2] | i_external_irq_zero_enable;

        port_value_override_enable[PBCAF_PB3] = i_timer1_match_a_enable & pin_dir[PBCAF_PB3];
        value_ovr_val[PBCAF_PB3] = i_timer1_match_a_wave;
        input_enable_override_enable[PBCAF_PB3] = pc_term[PBCAF_PB3] | adc_off[PBCAF_PB0_ADC - PBCAF_ADC_LSB + 3];
        input_ovr_val[PBCAF_PB3] = pc_term[PBCAF_PB3];

        port_value_override_enable[PBCAF_PC0] = (i_serial0_sync_mode & i_serial0_clock_out_enable)
            | (i_timer0_match_a_enable & pin_dir[PBCAF_PC0]);
        value_ovr_val[PBCAF_PC0] = (i_serial0_sync_mode & i_serial0_clock_out_enable)
            ? i_serial0_sync_clock : i_timer0_match_a_wave;
        input_enable_override_enable[PBCAF_PC0] = (i_serial0_sync_mode & ~i_serial0_clock_out_enable)
            | pc_term[PBCAF_PC0] | adc_off[PBCAF_PC0_ADC - PBCAF_ADC_LSB];
        input_ovr_val[PBCAF_PC0] = (i_serial0_sync_mode & ~i_serial0_clock_out_enable) | pc_term[PBCAF_PC0];

        // pc1: two-wire clock is open-drain like pb1
        pull_ovr_en[PBCAF_PC1] = i_serial_iface_two_wire_mode;
        dir_ovr_en[PBCAF_PC1] = i_serial_iface_two_wire_mode;
        dir_ovr_val[PBCAF_PC1] = (i_serial_iface_scl_hold | pin_latch[PBCAF_PC1]) & pin_dir[PBCAF_PC1];
        port_value_override_enable[PBCAF_PC1] = (i_serial1_sync_mode & i_serial1_clock_out_enable)
            | (i_serial_iface_two_wire_mode & pin_dir[PBCAF_PC1]);
        value_ovr_val[PBCAF_PC1] = ~i_serial_iface_two_wire_mode & i_serial1_sync_clock;
        // pc1 input kept on for its users
        input_enable_override_enable[PBCAF_PC1] = (i_serial1_sync_mode & ~i_serial1_clock_out_enable)
            | i_serial_start_detect_enable | pc_term[PBCAF_PC1] | adc_off[PBCAF_PC0_ADC - PBCAF_ADC_LSB + 1];
        input_ovr_val[PBCAF_PC1] = (i_serial1_sync_mode & ~i_serial1_clock_out_enable)
            | i_serial_start_detect_enable | pc_term[PBCAF_PC1];

        pull_ovr_en[PBCAF_PC2] = clock_out_on;
        dir_ovr_en[PBCAF_PC2] = clock_out_on;
        dir_ovr_val[PBCAF_PC2] = 1'h1;
        port_value_override_enable[PBCAF_PC2] = clock_out_on;
        value_ovr_val[PBCAF_PC2] = state.clk_image;
        input_enable_override_enable[PBCAF_PC2] = i_external_irq_zero_enable | pc_term[PBCAF_PC2]
            | adc_off[PBCAF_PC0_ADC - PBCAF_ADC_LSB + 2];
        input_ovr_val[PBCAF_PC2] = i_external_irq_zero_enable | pc_term[PBCAF_PC2];

        if (debug_role) begin
            pull_ovr_en[PBCAF_PC3] = 1'h1;
            pull_ovr_val[PBCAF_PC3] = 1'h1;
            dir_ovr_en[PBCAF_PC3] = 1'h1;
            dir_ovr_val[PBCAF_PC3] = i_debug_pull_low;
            port_value_override_enable[PBCAF_PC3] = 1'h1;
            input_enable_override_enable[PBCAF_PC3] = 1'h1;
            input_ovr_val[PBCAF_PC3] = 1'h1;
        end else if (reset_role) begin
            pull_ovr_en[PBCAF_PC3] = 1'h1;
            pull_ovr_val[PBCAF_PC3] = 1'h1;
            dir_ovr_en[PBCAF_PC3] = 1'h1;
            port_value_override_enable[PBCAF_PC3] = 1'h1;
            input_enable_override_enable[PBCAF_PC3] = 1'h1;
        end else begin
            input_enable_override_enable[PBCAF_PC3] = pc_term[PBCAF_PC3];
            input_ovr_val[PBCAF_PC3] = 1'h1;
        end

        pull_ovr_en[PBCAF_PC4] = xtal_role;
        dir_ovr_en[PBCAF_PC4] = xtal_role;
        port_value_override_enable[PBCAF_PC4] = xtal_role;
        input_enable_override_enable[PBCAF_PC4] = xtal_role | pc_term[PBCAF_PC4];
        input_ovr_val[PBCAF_PC4] = ~xtal_role & pc_term[PBCAF_PC4];
    end

    // =========================================================
    // pin cells
    genvar g;
    generate
        for (g = 0; g < PBCAF_ALL_PINS; g++) begin : gen_cell
            pbcaf_pin_cell u_cell (
                .i_latch(pin_latch[g]),
                .i_dir(pin_dir[g]),
                .i_pin(pin_level[g]),
                .i_pull_ovr_en(pull_ovr_en[g]),
                .i_pull_ovr_val(pull_ovr_val[g]),
                .i_dir_ovr_en(dir_ovr_en[g]),
                .i_dir_ovr_val(dir_ovr_val[g]),
                .i_port_value_override_enable(port_value_override_enable[g]),
                .i_value_ovr_val(value_ovr_val[g]),
                .i_input_enable_override_enable(input_enable_override_enable[g]),
                .i_input_ovr_val(input_ovr_val[g]),
                .o_pull_up(cell_pull[g]),
                .o_drive_en(cell_drive[g]),
                .o_out_value(cell_out[g]),
                .o_input_en(cell_in_en[g]),
                .o_data_in(cell_di[g])
            );
        end
    endgenerate

    // =========================================================
    // next state
    always_comb begin
        next_state = state;
        next_state.pull_up = cell_pull;
        next_state.drive_en = cell_drive;
        next_state.out_value = cell_out;
        next_state.input_en = cell_in_en;
        // pc sources 12..17; pc5 passes raw
        next_state.pin_change_src = {i_pin_pc[PBCAF_PC5_PCINT - PBCAF_PC_PCINT_BASE], cell_di};
        // a flop image of the clock runs at half rate; a real pad
        // would take the clock net itself, not a register
        if (state.clk_image) begin
            next_state.clk_image = 1'h0;
        end else begin
            next_state.clk_image = 1'h1;
        end
        next_state.ext_reset_n = reset_role ? pin_level[PBCAF_PC3] : 1'h1;
        next_state.debug_in = debug_role & cell_di[PBCAF_PC3];
        next_state.serial1_rx = cell_di[PBCAF_PB1];
        next_state.serial0_rx_unused = 1'h0;
        next_state.iface_data_in = cell_di[PBCAF_PB1];
        next_state.iface_clock_in = cell_di[PBCAF_PC1];
        next_state.capture_in = cell_di[PBCAF_PC1];
        next_state.irq_zero_in = cell_di[PBCAF_PC2];
        next_state.serial0_clk_in = i_serial0_sync_mode & cell_di[PBCAF_PC0];
        next_state.serial1_clk_in = i_serial1_sync_mode & cell_di[PBCAF_PC1];
        if (!i_reset_n) begin
            // pads float during reset, except pc2, driven with the clock image when clock_out_on
            next_state.pull_up = PBCAF_RST_PINS;
            next_state.drive_en = PBCAF_RST_PINS;
            next_state.out_value = PBCAF_RST_PINS;
            next_state.input_en = PBCAF_RST_PINS;
            next_state.pin_change_src = PBCAF_RST_PCINT;
            next_state.ext_reset_n = PBCAF_RST_HIGH;
            next_state.debug_in = PBCAF_RST_LOW;
            next_state.serial1_rx = PBCAF_RST_LOW;
            next_state.iface_data_in = PBCAF_RST_LOW;
            next_state.iface_clock_in = PBCAF_RST_LOW;
            next_state.capture_in = PBCAF_RST_LOW;
            next_state.irq_zero_in = PBCAF_RST_LOW;
            next_state.serial0_clk_in = PBCAF_RST_LOW;
            next_state.serial1_clk_in = PBCAF_RST_LOW;
            if (clock_out_on) begin
                next_state.drive_en[PBCAF_PC2] = 1'h1;
                next_state.out_value[PBCAF_PC2] = ~next_state.clk_image;
            end else begin
                next_state.clk_image = PBCAF_RST_LOW;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        state <= next_state;
    end

    // =========================================================
    // outputs straight from the state register
    assign o_pull_up = state.pull_up;
    assign o_drive_en = state.drive_en;
    assign o_out_value = state.out_value;
    assign o_input_en = state.input_en;
    assign o_pin_change_src = state.pin_change_src;
    assign o_external_reset_n = state.ext_reset_n;
    assign o_debug_link_in = state.debug_in;
    assign o_serial1_receive = state.serial1_rx;
    assign o_serial_iface_data_in = state.iface_data_in;
    assign o_serial_iface_clock_in = state.iface_clock_in;
    assign o_timer1_capture_input = state.capture_in;
    assign o_external_irq_zero = state.irq_zero_in;
    assign o_serial0_sync_clock_in = state.serial0_clk_in;
    assign o_serial1_sync_clock_in = state.serial1_clk_in;
endmodule
`default_nettype wire

// ### verif/pbcaf_checker.sv
// pbcaf_checker: pin override properties, one cycle latency
// assumes: bound to pbcaf_override, single clock domain
`timescale 1ns/10ps
`default_nettype none
module pbcaf_checker (
    input wire logic i_clk, i_reset_n, i_timer1_match_a_enable, i_timer1_match_a_wave, i_serial1_tx_enable,
    input wire logic i_serial1_transmit, i_serial_iface_three_wire_mode, i_serial_iface_data_out,
    input wire logic i_clock_output_fuse, i_reset_pin_disable_fuse, i_debug_link_enable_fuse,
    input wire logic i_lock_bits_unprogrammed, i_debug_pull_low,
    input wire logic [3:0] i_pb_dir, i_pb_latch,
    input wire pbcaf_pkg::pbcaf_clk_src_t i_clock_source,
    input wire logic [8:0] o_pull_up, o_drive_en, o_out_value, o_input_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ==========
    // overrides
    wire logic tw = i_serial_iface_three_wire_mode && !i_serial1_tx_enable;
    property p_t1; i_timer1_match_a_enable && i_pb_dir[3] |=> o_out_value[3] == $past(i_timer1_match_a_wave); endproperty
    a_t1: assert property (p_t1) else $error("pb3 wave");
    property p_tx1; i_serial1_tx_enable |=> o_drive_en[2] && o_out_value[2] == $past(i_serial1_transmit); endproperty
    a_tx1: assert property (p_tx1) else $error("pb2 tx");
    property p_do; tw && i_pb_dir[2] |=> o_drive_en[2] && o_out_value[2] == $past(i_serial_iface_data_out); endproperty
    a_do: assert property (p_do) else $error("pb2 data out");
    property p_pu; tw && !i_pb_dir[2] |=> o_pull_up[2] == $past(i_pb_latch[2]); endproperty
    a_pu: assert property (p_pu) else $error("pb2 pull");
    // three cycles: the image flop must be running before it toggles
    sequence s_ck; !i_clock_output_fuse [*3]; endsequence
    property p_ck; s_ck |-> o_drive_en[6] && o_out_value[6] != $past(o_out_value[6]); endproperty
    a_ck: assert property (p_ck) else $error("pc2 clock");
    property p_rst; i_reset_pin_disable_fuse && i_debug_link_enable_fuse |=> o_pull_up[7] && !o_drive_en[7] && !o_input_en[7]; endproperty
    a_rst: assert property (p_rst) else $error("pc3 reset role");
    property p_dbg; !i_debug_link_enable_fuse && i_lock_bits_unprogrammed |=>
        o_pull_up[7] && !o_out_value[7] && o_drive_en[7] == $past(i_debug_pull_low); endproperty
    a_dbg: assert property (p_dbg) else $error("pc3 debug");
    property p_xt; i_clock_source[1] |=> !o_drive_en[8] && !o_pull_up[8] && !o_input_en[8]; endproperty
    a_xt: assert property (p_xt) else $error("pc4 crystal");
endmodule
bind pbcaf_override pbcaf_checker u_chk (.*);
`default_nettype wire

// ### verif/pbcaf_pads.sv
// pbcaf_pads: pad model, pb0..pb3 then pc0..pc5
// assumes: bench drives the outside only where it enables it
`timescale 1ns/10ps
`default_nettype none
module pbcaf_pads (
    input wire logic i_clk,
    input wire logic [8:0] i_de, i_ov, i_pu,
    input wire logic [9:0] i_ext_en, i_ext_val,
    output logic [9:0] o_lvl
);
    // wired-and, lows win; floating pads wander
    always @(posedge i_clk)
        for (int k = 0; k < 10; k++)
            o_lvl[k] <= (k < 9 && i_de[k] && !i_ov[k]) || (i_ext_en[k] && !i_ext_val[k]) ? 1'h0 :
                (k < 9 && (i_de[k] || i_pu[k])) || i_ext_en[k] ? 1'h1 : o_lvl[k] !== 1'h1;
endmodule
`default_nettype wire

// ### verif/pbcaf_override_tb_top.sv
// pbcaf_override_tb_top: directed tests of the pin override block
// assumes: pad model and bound checker alongside
`timescale 1ns/10ps
`default_nettype none
module pbcaf_override_tb_top;
    import pbcaf_pkg::*;
    logic i_clk = '0, i_reset_n = '0, i_pin_change_group1_enable = '0, i_pin_change_group2_enable = '0, v;
    logic i_serial0_tx_enable = '0, i_serial0_transmit = '0, i_serial1_tx_enable = '0, i_serial1_transmit = '0;
    logic i_serial1_rx_enable = '0, i_serial_iface_three_wire_mode = '0, i_serial_iface_two_wire_mode = '0;
    logic i_serial_iface_data_out = '0, i_serial_iface_sda_hold = '0, i_serial_iface_scl_hold = '0;
    logic i_serial_start_detect_enable = '0, i_timer1_match_a_enable = '0, i_timer1_match_a_wave = '0;
    logic i_timer0_match_a_enable = '0, i_timer0_match_a_wave = '0, i_serial0_sync_mode = '0;
    logic i_serial0_clock_out_enable = '0, i_serial0_sync_clock = '0, i_serial1_sync_mode = '0;
    logic i_serial1_clock_out_enable = '0, i_serial1_sync_clock = '0, i_external_irq_zero_enable = '0;
    logic i_clock_output_fuse = '0, i_reset_pin_disable_fuse = '0, i_debug_link_enable_fuse = '0;
    logic i_lock_bits_unprogrammed = '0, i_debug_pull_low = '0;
    logic [3:0] i_pb_latch = '0, i_pb_dir = '0, i_pin_pb;
    logic [4:0] i_pc_latch = '0, i_pc_dir = '0;
    logic [5:0] i_pin_pc;
    logic [9:0] i_pin_change_mask = '0, o_pin_change_src, ext_en = '0, ext_val = '0;
    logic [6:0] i_conv_dig_input_disable = '0;
    pbcaf_clk_src_t i_clock_source = PBCAF_CLK_INT_CAL;
    logic [8:0] o_pull_up, o_drive_en, o_out_value, o_input_en;
    logic o_external_reset_n, o_debug_link_in, o_serial1_receive, o_serial_iface_data_in, o_serial_iface_clock_in;
    logic o_timer1_capture_input, o_external_irq_zero, o_serial0_sync_clock_in, o_serial1_sync_clock_in;
    int err_count = 0, n_tests = 0;
    pbcaf_override DUT (.*);
    pbcaf_pads u_pads (.i_clk(i_clk), .i_de(o_drive_en), .i_ov(o_out_value), .i_pu(o_pull_up),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_lvl({i_pin_pc, i_pin_pb}));
    always #10 i_clk = ~i_clk;
    // ==========
    // helpers
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        go(1);
        chk(o_drive_en, 9'h040);
        @(posedge i_clk);
        i_reset_n <= 1'h1;
        i_pb_dir <= 4'hD;
        i_pb_latch <= 4'h5;
        i_serial_iface_three_wire_mode <= 1'h1;
        i_timer1_match_a_enable <= 1'h1;
        i_timer1_match_a_wave <= 1'h1;
        go(3);
        v = o_out_value[6];
        chk(o_out_value[3:0], 4'h9);
        chk(o_drive_en[3:0], 4'hD);
        go(1);
        chk(o_out_value[6], !v);
        @(posedge i_clk);
        i_pb_dir <= 4'h1;
        go(3);
        chk(o_pull_up[3:0], 4'h4);
        chk(o_out_value[3], 1'h0);
        @(posedge i_clk);
        i_serial1_tx_enable <= 1'h1;
        i_serial1_transmit <= 1'h1;
        i_conv_dig_input_disable <= 7'h0F;
        i_external_irq_zero_enable <= 1'h1;
        go(3);
        chk({o_drive_en[2], o_out_value[2]}, 2'h3);
        chk(o_input_en[1:0], 2'h0);
        chk(o_input_en[3:2], 2'h1);
        $display("test port_b done");
        @(posedge i_clk);
        i_reset_pin_disable_fuse <= 1'h1;
        i_debug_link_enable_fuse <= 1'h1;
        ext_en <= 10'h080;
        go(3);
        chk({o_pull_up[7], o_drive_en[7], o_input_en[7], o_external_reset_n}, 4'h8);
        @(posedge i_clk);
        i_debug_link_enable_fuse <= 1'h0;
        i_lock_bits_unprogrammed <= 1'h1;
        i_debug_pull_low <= 1'h1;
        ext_en <= 10'h000;
        go(3);
        chk({o_pull_up[7], o_drive_en[7], o_out_value[7], i_pin_pc[3]}, 4'hC);
        $display("test pc3 done");
        for (int s = 0; s < 4; s++) begin
            @(posedge i_clk);
            i_clock_source <= pbcaf_clk_src_t'(s);
            i_pc_dir <= 5'h10;
            go(3);
            chk(o_drive_en[8], s < 2);
        end
        @(posedge i_clk);
        i_pb_dir <= 4'h0;
        i_serial1_tx_enable <= 1'h0;
        i_serial_iface_three_wire_mode <= 1'h0;
        i_conv_dig_input_disable <= 7'h00;
        i_pc_dir <= 5'h11;
        i_timer0_match_a_enable <= 1'h1;
        i_timer0_match_a_wave <= 1'h1;
        i_serial1_sync_mode <= 1'h1;
        ext_en <= 10'h02F;
        ext_val <= 10'h026;
        go(4);
        chk(o_pin_change_src[3:0], 4'h6);
        chk(o_pin_change_src[5:4], 2'h3);
        chk({o_drive_en[4], o_out_value[4]}, 2'h3);
        chk(o_serial1_sync_clock_in, 1'h1);
        chk({o_timer1_capture_input, o_serial_iface_clock_in}, 2'h3);
        chk({o_serial1_receive, o_serial_iface_data_in}, 2'h3);
        $display("test pc4_and_pin_change done");
        end_sim;
    end
    initial begin
        #20us;
        err_count++;
        end_sim;
    end
endmodule
`default_nettype wire
